//--- regbank_pkg.sv
// shared constants and carrier types for the generic register bank core
package regbank_pkg;

    // =========================================================
    // address map
    localparam int            ADDR_WIDTH       = 9;
    localparam int            DATA_WIDTH       = 32;
    localparam logic [8:0]    SYS_REGION_LO    = 9'h000;
    localparam logic [8:0]    SYS_REGION_HI    = 9'h0FF;
    localparam logic [8:0]    MAC_REGION_LO    = 9'h100;
    localparam logic [8:0]    MAC_REGION_HI    = 9'h1FC;

    // =========================================================
    // reset values
    localparam logic [31:0]   ZERO_WORD        = 32'h0000_0000;

    // =========================================================
    // per-bit access attribute
    typedef enum logic [3:0] {
        ATTR_RW       = 4'h0,
        ATTR_RO       = 4'h1,
        ATTR_SET_READ = 4'h2,
        ATTR_WO       = 4'h3,
        ATTR_W1C      = 4'h4,
        ATTR_WAC      = 4'h5,
        ATTR_COR      = 4'h6,
        ATTR_LATCH_LO = 4'h7,
        ATTR_LATCH_HI = 4'h8,
        ATTR_SELF_CLR = 4'h9,
        ATTR_PHY_LH   = 4'hA,
        ATTR_RSVD     = 4'hB
    } bit_attr_type;

    // region decode result
    typedef enum logic [2:0] {
        REGION_NONE = 3'b001,
        REGION_SYS  = 3'b010,
        REGION_MAC  = 3'b100
    } region_type;

    // one register access from the host-side port
    typedef struct packed {
        logic        read;
        logic        write;
        logic [8:0]  addr;
        logic [31:0] wdata;
    } access_type;

endpackage

//--- register_access_semantics.sv
// generic register bank core with per-bit access attributes and region decode
`timescale 1ns/1ps

module register_access_semantics
    import regbank_pkg::*;
#(
    parameter int                      NUM_REGS   = 8,
    parameter bit_attr_type            ATTR_MAP [NUM_REGS][32] = '{default: ATTR_RW},
    parameter logic [31:0]             IMMUNE_MAP [NUM_REGS]   = '{default: 32'h0000_0000},
    parameter logic [31:0]             RESET_MAP  [NUM_REGS]   = '{default: 32'h0000_0000}
) (
    // clock and resets
    input  wire logic                       clock,
    input  wire logic                       reset_n,
    input  wire logic                       soft_reset,
    // register access port
    input  wire regbank_pkg::access_type    access,
    output logic [31:0]                     rdata,
    output logic                            rvalid,
    output regbank_pkg::region_type         region,
    // hardware side: live status and set events per bit
    input  wire logic [NUM_REGS*32-1:0]     hw_status,
    input  wire logic [NUM_REGS*32-1:0]     hw_set,
    // stored contents for the block's own logic
    output logic [NUM_REGS*32-1:0]          reg_value
);
    import regbank_pkg::*;

    // =========================================================
    // region decode
    function automatic region_type decode_region(input logic [8:0] a);
        if (a <= SYS_REGION_HI) begin
            return REGION_SYS;
        end else if (a >= MAC_REGION_LO && a <= MAC_REGION_HI) begin
            return REGION_MAC;
        end
        return REGION_NONE;
    endfunction

    // register index within the bank: word address, low region first
    function automatic logic [6:0] word_index(input logic [8:0] a);
        return a[8:2];
    endfunction

    region_type          region_now;
    logic [6:0]          idx;
    logic                hit_any;
    logic [NUM_REGS-1:0] hit;
    logic [31:0]         store_reg [NUM_REGS];
    logic [31:0]         read_done_reg [NUM_REGS];

    assign region_now = decode_region(access.addr);
    assign idx        = word_index(access.addr);

    always_comb begin
        hit = '0;
        for (int r = 0; r < NUM_REGS; r++) begin
            // outside both regions nothing is selected
            // unaligned or unpopulated words select nothing either, so they read as zero
            hit[r] = (region_now != REGION_NONE) && (idx == 7'(r)) && (access.addr[1:0] == 2'b00);
        end
        hit_any = |hit;
    end

    // =========================================================
    // per-bit next value
    function automatic logic bit_next(
        input bit_attr_type at,
        input logic         cur,
        input logic         rd,
        input logic         wr,
        input logic         wd,
        input logic         live,
        input logic         set_ev,
        input logic         seen
    );
        logic n;
        n = cur;
        unique case (at)
            ATTR_RW, ATTR_WO: begin
                if (wr) n = wd;
            end
            ATTR_RO: n = live;
            ATTR_SET_READ: begin
                if (wr) n = wd;
                if (rd) n = 1'b1;
            end
            ATTR_W1C: begin
                if (wr && wd) n = 1'b0;
                if (set_ev) n = 1'b1;
            end
            ATTR_WAC: begin
                if (wr) n = 1'b0;
                if (set_ev) n = 1'b1;
            end
            ATTR_COR: begin
                // an event in the read cycle wins so it is not lost
                if (rd) n = 1'b0;
                if (set_ev) n = 1'b1;
            end
            ATTR_LATCH_HI: begin
                if (rd) n = 1'b0;
                if (live) n = 1'b1;
            end
            ATTR_LATCH_LO: begin
                if (rd) n = 1'b1;
                if (!live) n = 1'b0;
            end
            ATTR_SELF_CLR: begin
                // set holds for exactly one cycle, then clears by itself
                n = (wr && wd) ? 1'b1 : 1'b0;
            end
            ATTR_PHY_LH: begin
                // seen: a read came while the bit was high, so the bit now follows its cause
                if (live) n = 1'b1;
                else if (seen || rd) n = 1'b0;
            end
            ATTR_RSVD: n = 1'b0;
            default: n = cur;
        endcase
        return n;
    endfunction

    // =========================================================
    // storage: hardware reset clears all, soft reset spares immune bits
    generate
        for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
            logic [31:0] next_word;
            logic [31:0] seen_next;
            logic        rd;
            logic        wr;
            assign rd = access.read && hit[r];
            assign wr = access.write && hit[r];
            always_comb begin
                next_word = store_reg[r];
                seen_next = read_done_reg[r];
                for (int b = 0; b < 32; b++) begin
                    next_word[b] = bit_next(ATTR_MAP[r][b], store_reg[r][b], rd, wr, access.wdata[b],
                                            hw_status[r*32+b], hw_set[r*32+b], read_done_reg[r][b]);
                    // read seen: arms the phy bit to follow its cause
                    if (rd && store_reg[r][b]) seen_next[b] = 1'b1;
                    if (!next_word[b]) seen_next[b] = 1'b0;
                end
            end
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    store_reg[r]     <= ZERO_WORD;
                    read_done_reg[r] <= ZERO_WORD;
                end else if (soft_reset) begin
                    // a software reset beats any access in the same cycle
                    store_reg[r]     <= (store_reg[r] & IMMUNE_MAP[r]) | (RESET_MAP[r] & ~IMMUNE_MAP[r]);
                    read_done_reg[r] <= read_done_reg[r] & IMMUNE_MAP[r];
                end else begin
                    store_reg[r]     <= next_word;
                    read_done_reg[r] <= seen_next;
                end
            end
            assign reg_value[r*32 +: 32] = store_reg[r];
        end
    endgenerate

    // =========================================================
    // read view of one bit
    // write-only and reserved bits are hidden rather than leaking stored data
    function automatic logic read_bit(
        input bit_attr_type at,
        input logic         stored,
        input logic         live
    );
        logic v;
        v = stored;
        unique case (at)
            ATTR_RO:            v = live;
            ATTR_WO, ATTR_RSVD: v = 1'b0;
            default:            v = stored;
        endcase
        return v;
    endfunction

    // =========================================================
    // read data: registered, one cycle after the request
    logic [31:0] rdata_next;
    always_comb begin
        rdata_next = ZERO_WORD;
        for (int r = 0; r < NUM_REGS; r++) begin
            if (hit[r]) begin
                for (int b = 0; b < 32; b++) begin
                    rdata_next[b] = read_bit(ATTR_MAP[r][b], store_reg[r][b], hw_status[r*32+b]);
                end
            end
        end
    end

    // =========================================================
    // outputs
    // rdata carries the word as it stood before the read's own side effects
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata  <= ZERO_WORD;
            rvalid <= 1'b0;
            region <= REGION_NONE;
        end else begin
            rdata  <= (access.read && hit_any) ? rdata_next : ZERO_WORD;
            rvalid <= access.read;
            region <= region_now;
        end
    end

endmodule

//--- register_access_semantics_asserts.sv
// concurrent checks on the register bank core ports
`timescale 1ns/1ps
module register_access_semantics_asserts
    import regbank_pkg::*;
#(
    parameter int NUM_REGS = 8
) (
    // clock and resets
    input wire logic                     clock,
    input wire logic                     reset_n,
    input wire logic                     soft_reset,
    // access port
    input wire regbank_pkg::access_type  access,
    input wire logic [31:0]              rdata,
    input wire logic                     rvalid,
    input wire regbank_pkg::region_type  region,
    // hardware side
    input wire logic [NUM_REGS*32-1:0]   hw_status,
    input wire logic [NUM_REGS*32-1:0]   hw_set,
    input wire logic [NUM_REGS*32-1:0]   reg_value
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // =========================================================
    // decode and bit behaviour; bank layout is the bench's four registers
    property p_sys; access.addr <= 9'h0FF |=> region == REGION_SYS; endproperty
    a_sys: assert property (p_sys) else $error("system decode wrong");
    property p_mac; access.addr inside {[9'h100:9'h1FC]} |=> region == REGION_MAC; endproperty
    a_mac: assert property (p_mac) else $error("mac decode wrong");
    property p_none; access.addr > 9'h1FC |=> region == REGION_NONE; endproperty
    a_none: assert property (p_none) else $error("outside decode wrong");
    property p_w1c; access.write && access.addr == 9'h004 && !soft_reset && hw_set[63:32] == 32'h0
        |=> reg_value[63:32] == ($past(reg_value[63:32]) & ~$past(access.wdata)); endproperty
    a_w1c: assert property (p_w1c) else $error("write one clear wrong");
    property p_cor; access.read && access.addr == 9'h008 && !soft_reset && hw_set[95:64] == 32'h0
        |=> reg_value[95:64] == 32'h0; endproperty
    a_cor: assert property (p_cor) else $error("clear on read kept data");
    property p_sor; access.read && access.addr == 9'h00C && !soft_reset |=> reg_value[96]; endproperty
    a_sor: assert property (p_sor) else $error("set on read not set");
    property p_sclr; reg_value[98] && !(access.write && access.wdata[2]) |=> !reg_value[98]; endproperty
    a_sclr: assert property (p_sclr) else $error("self clear stuck");
    property p_imm; soft_reset |=> reg_value[127:112] == $past(reg_value[127:112]); endproperty
    a_imm: assert property (p_imm) else $error("immune bits changed");
    property p_wac; access.write && access.addr == 9'h00C && !soft_reset && !hw_set[97]
        |=> !reg_value[97]; endproperty
    a_wac: assert property (p_wac) else $error("write any clear kept data");
    property p_ro; access.read && access.addr == 9'h000 |=> rdata == $past(hw_status[31:0]); endproperty
    a_ro: assert property (p_ro) else $error("read only data wrong");
    property p_oob; access.read && access.addr > 9'h1FC |=> rdata == 32'h0; endproperty
    a_oob: assert property (p_oob) else $error("outside read not zero");
endmodule
bind register_access_semantics register_access_semantics_asserts #(.NUM_REGS(NUM_REGS)) u_asserts (
    .clock(clock), .reset_n(reset_n), .soft_reset(soft_reset), .access(access), .rdata(rdata),
    .rvalid(rvalid), .region(region), .hw_status(hw_status), .hw_set(hw_set), .reg_value(reg_value));

//--- register_access_semantics_bench.sv
// self-checking bench for the register bank core
`timescale 1ns/1ps
module register_access_semantics_bench;
    import regbank_pkg::*;
    logic         clock, reset_n, soft_reset, rvalid;
    access_type   access;
    logic [31:0]  rdata, d;
    region_type   region;
    logic [127:0] hw_status, hw_set, reg_value;
    int           n_errors, checked;
    // =========================================================
    // bank: ro, write-one-clear, clear-on-read, mixed
    localparam bit_attr_type MAP [4][32] = '{'{default: ATTR_RO}, '{default: ATTR_W1C}, '{default: ATTR_COR},
        '{0: ATTR_SET_READ, 1: ATTR_WAC, 2: ATTR_SELF_CLR, 3: ATTR_PHY_LH, 4: ATTR_LATCH_HI,
          5: ATTR_RSVD, default: ATTR_RW}};
    localparam logic [31:0] IMM [4] = '{32'h0, 32'h0, 32'h0, 32'hFFFF_0000};
    register_access_semantics #(.NUM_REGS(4), .ATTR_MAP(MAP), .IMMUNE_MAP(IMM)) DUT (.clock(clock),
        .reset_n(reset_n), .soft_reset(soft_reset), .access(access), .rdata(rdata), .rvalid(rvalid),
        .region(region), .hw_status(hw_status), .hw_set(hw_set), .reg_value(reg_value));
    // =========================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] v);
        access = '{1'b0, 1'b1, a, v};
        step(1);
        access.write = 1'b0;
        // idle edge so a following call never re-raises the strobe in this time step
        step(1);
    endtask
    task automatic rd(input logic [8:0] a);
        access = '{1'b1, 1'b0, a, 32'h0};
        step(1);
        access.read = 1'b0;
        d = rdata;
        check({31'h0, rvalid}, 32'h1);
        step(1);
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // =========================================================
    // scenarios
    task automatic t_clear;
        hw_status[31:0] = 32'hA5A5_0F0F;
        wr(9'h000, 32'hFFFF_FFFF);
        rd(9'h000); check(d, 32'hA5A5_0F0F);
        hw_set = {32'h0, 32'h0000_1234, 32'hFFFF_FFFF, 32'h0};
        step(1);
        hw_set = '0;
        wr(9'h004, 32'h0000_00FF);
        wr(9'h004, 32'h0);
        wr(9'h008, 32'hFFFF_FFFF);
        rd(9'h004); check(d, 32'hFFFF_FF00);
        rd(9'h008); check(d, 32'h0000_1234);
        rd(9'h008); check(d, 32'h0);
        $display("t_clear done");
    endtask
    task automatic t_bits;
        rd(9'h00C);
        hw_set[97] = 1'b1;
        step(1);
        hw_set[97] = 1'b0;
        rd(9'h00C); check(d & 32'h3, 32'h3);
        wr(9'h00C, 32'h0);
        rd(9'h00C); check(d & 32'h2, 32'h0);
        access = '{1'b0, 1'b1, 9'h00C, 32'h4};
        step(1);
        access.write = 1'b0;
        check(reg_value[127:96] & 32'h4, 32'h4);
        step(1); check(reg_value[127:96] & 32'h4, 32'h0);
        hw_status[100:99] = 2'b11;
        step(1);
        hw_status[100:99] = 2'b00;
        step(2);
        rd(9'h00C); check(d & 32'h18, 32'h18);
        rd(9'h00C); check(d & 32'h18, 32'h0);
        hw_status[99] = 1'b1;
        step(2);
        rd(9'h00C);
        rd(9'h00C); check(d & 32'h8, 32'h8);
        hw_status[99] = 1'b0;
        step(1);
        rd(9'h00C); check(d & 32'h8, 32'h0);
        $display("t_bits done");
    endtask
    task automatic t_map;
        wr(9'h00C, 32'hFFFF_FFC0);
        soft_reset = 1'b1;
        step(1);
        soft_reset = 1'b0;
        check(reg_value[127:96] & 32'hFFFF_FFE0, 32'hFFFF_0000);
        wr(9'h1FE, 32'hFFFF_FFFF);
        rd(9'h1FE); check(d, 32'h0);
        check(reg_value[127:96], 32'hFFFF_0000);
        rd(9'h1FC); check({29'h0, region}, {29'h0, REGION_MAC});
        rd(9'h0FC); check({29'h0, region}, {29'h0, REGION_SYS});
        reset_n = 1'b0;
        step(1);
        check(reg_value[127:96], 32'h0);
        check(reg_value[63:32], 32'h0);
        reset_n = 1'b1;
        step(1);
        $display("t_map done");
    endtask
    // =========================================================
    // clock, watchdog, sequence
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        #20000;
        n_errors++;
        end_of_test;
    end
    initial begin
        {reset_n, soft_reset, access, hw_status, hw_set} = '0;
        n_errors = 0;
        checked = 0;
        step(5);
        reset_n = 1'b1;
        t_clear;
        t_bits;
        t_map;
        end_of_test;
    end
endmodule
